// ===== verilog/twf_defines.vh
// Register map, field positions, reset values and timing constants of the twin flicker timer
`ifndef TWF_DEFINES_VH
`define TWF_DEFINES_VH

// Register byte offsets
`define TWF_REG_CTRL 8'h00
`define TWF_REG_ON_SET 8'h04
`define TWF_REG_OFF_SET 8'h08
`define TWF_REG_ON_LIMIT 8'h0C
`define TWF_REG_OFF_LIMIT 8'h10
`define TWF_REG_ALARM 8'h14
`define TWF_REG_STATUS 8'h18
`define TWF_REG_PV 8'h1C
`define TWF_REG_CNT_ALL 8'h20
`define TWF_REG_CNT_ONE 8'h24
`define TWF_REG_CNT_TWO 8'h28
`define TWF_REG_RUNTIME 8'h2C
`define TWF_REG_POWER 8'h30

// Control register fields
`define TWF_CTRL_RUN 0
`define TWF_CTRL_DOWN 1
`define TWF_CTRL_ON_START 2
`define TWF_CTRL_WIDTH_1MS 3
`define TWF_CTRL_TWIN_LIMIT 4
`define TWF_CTRL_INV_ONE 5
`define TWF_CTRL_INV_TWO 6
`define TWF_CTRL_RETAIN 7
`define TWF_CTRL_IND_LO 8
`define TWF_CTRL_IND_HI 9
`define TWF_CTRL_ON_RNG_LO 12
`define TWF_CTRL_ON_RNG_HI 14
`define TWF_CTRL_OFF_RNG_LO 16
`define TWF_CTRL_OFF_RNG_HI 18
`define TWF_CTRL_MASK 32'h0007737F
`define TWF_CTRL_RESET 32'h00000001

// Indicator modes
`define TWF_IND_RATIO 2'h0
`define TWF_IND_DARK 2'h1
`define TWF_IND_LIT 2'h2

// Values and limits
`define TWF_VALUE_MAX 20'hF423F
`define TWF_LIMIT_MIN 20'h00001
`define TWF_ALARM_MAX 14'h270F
`define TWF_ALARM_RESET 14'h0064
`define TWF_KILO 10'h3E8

// Timing
`define TWF_CLK_HZ 200000000
`define TWF_MS_PER_S 1000
`define TWF_WIDTH_LONG_MS 5'h14
`define TWF_WIDTH_SHORT_MS 5'h01
`define TWF_TENTH_YEAR_S 3153600

`endif

// ===== verilog/twf_timer.v
// Twin flicker timer with AXI4-Lite register access, ON-count and run-time monitors
`timescale 1ns/100ps
`default_nettype none
`include "twf_defines.vh"

module twf_timer #(
  parameter integer MS_CYCLES = `TWF_CLK_HZ / `TWF_MS_PER_S,
  parameter integer TENTH_YEAR_S = `TWF_TENTH_YEAR_S,
  parameter integer SEC_MS = `TWF_MS_PER_S
) (
  input wire ref_clk_in,
  input wire srst_in,
  input wire start_in,
  input wire reset_in,
  input wire gate_in,
  output reg control_output_one_out,
  output reg control_output_two_out,
  output reg [5:0] indicators_out,
  output reg replacement_due_error_out,
  input wire [7:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [7:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in
);

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer b;
    begin
      merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[8*b +: 8] = new_v[8*b +: 8];
        end
      end
    end
  endfunction

  // Milliseconds per count unit of a time range
  function [21:0] range_ms;
    input [2:0] rng;
    begin
      case (rng)
        3'h0: range_ms = 22'h000001;
        3'h1: range_ms = 22'h00000A;
        3'h2: range_ms = 22'h000064;
        3'h3: range_ms = 22'h0003E8;
        3'h4: range_ms = 22'h001770;
        3'h5: range_ms = 22'h00EA60;
        3'h6: range_ms = 22'h057E40;
        default: range_ms = 22'h36EE80;
      endcase
    end
  endfunction

  // Lit pattern from the left for the ratio of value over set value
  function [5:0] ratio_pattern;
    input [19:0] val;
    input [19:0] set;
    integer k;
    reg [22:0] six_val;
    begin
      six_val = {3'h0, val} * 23'h6;
      ratio_pattern = 6'h00;
      for (k = 1; k <= 6; k = k + 1) begin
        if (six_val >= ({3'h0, set} * k[22:0])) begin
          ratio_pattern[6 - k] = 1'b1;
        end
      end
    end
  endfunction

  reg [31:0] ctrl_q;
  reg [19:0] on_set_q;
  reg [19:0] off_set_q;
  reg [19:0] on_limit_q;
  reg [19:0] off_limit_q;
  reg [13:0] alarm_q;
  reg power_evt_q;

  wire run_w = ctrl_q[`TWF_CTRL_RUN];
  wire down_w = ctrl_q[`TWF_CTRL_DOWN];
  wire [1:0] ind_mode_w = ctrl_q[`TWF_CTRL_IND_HI:`TWF_CTRL_IND_LO];
  wire [4:0] width_ms_w = ctrl_q[`TWF_CTRL_WIDTH_1MS] ? `TWF_WIDTH_SHORT_MS :
                          `TWF_WIDTH_LONG_MS;

  // Millisecond enable
  reg [31:0] ms_cnt_q;
  wire ms_tick_w = (ms_cnt_q == MS_CYCLES - 1);
  always @(posedge ref_clk_in) begin
    if (srst_in || ms_tick_w) begin
      ms_cnt_q <= 32'h0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'h1;
    end
  end

  // Input qualification: a level must hold for the selected width before it is taken
  wire [2:0] raw_w = {gate_in, reset_in, start_in};
  reg [2:0] filt_q;
  reg [4:0] qual_q [0:2];
  integer i;
  always @(posedge ref_clk_in) begin
    for (i = 0; i < 3; i = i + 1) begin
      if (srst_in) begin
        filt_q[i] <= 1'b0;
        qual_q[i] <= 5'h0;
      end else if (raw_w[i] == filt_q[i]) begin
        qual_q[i] <= 5'h0;
      end else if (ms_tick_w) begin
        // Needs one tick beyond the width, so a pulse shorter than the width never passes
        if (qual_q[i] >= width_ms_w) begin
          filt_q[i] <= raw_w[i];
          qual_q[i] <= 5'h0;
        end else begin
          qual_q[i] <= qual_q[i] + 5'h1;
        end
      end
    end
  end
  wire start_f = filt_q[0];
  wire reset_f = filt_q[1];
  wire gate_f = filt_q[2];

  // Flicker core
  reg timing_q;
  reg flick_q;
  reg [19:0] elapsed_q;
  reg [21:0] unit_q;
  wire [19:0] cur_set_w = flick_q ? on_set_q : off_set_q;
  wire [2:0] cur_rng_w = flick_q ? ctrl_q[`TWF_CTRL_ON_RNG_HI:`TWF_CTRL_ON_RNG_LO] :
                         ctrl_q[`TWF_CTRL_OFF_RNG_HI:`TWF_CTRL_OFF_RNG_LO];
  wire unit_tick_w = ms_tick_w && (unit_q + 22'h1 >= range_ms(cur_rng_w));
  wire [19:0] remain_w = (cur_set_w > elapsed_q) ? cur_set_w - elapsed_q : 20'h0;
  wire [19:0] pv_w = down_w ? remain_w : elapsed_q;

  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      timing_q <= 1'b0;
      flick_q <= 1'b0;
      elapsed_q <= 20'h0;
      unit_q <= 22'h0;
    end else if (!run_w || reset_f) begin
      timing_q <= 1'b0;
      flick_q <= 1'b0;
      elapsed_q <= 20'h0;
      unit_q <= 22'h0;
    end else if (power_evt_q) begin
      if (!ctrl_q[`TWF_CTRL_RETAIN]) begin
        timing_q <= 1'b0;
        flick_q <= 1'b0;
        elapsed_q <= 20'h0;
        unit_q <= 22'h0;
      end
    end else if (!timing_q) begin
      if (start_f) begin
        timing_q <= 1'b1;
        flick_q <= ctrl_q[`TWF_CTRL_ON_START];
        elapsed_q <= 20'h0;
        unit_q <= 22'h0;
      end
    end else if (!gate_f && ms_tick_w) begin
      // Start is not looked at here while timing
      if (unit_tick_w) begin
        unit_q <= 22'h0;
        if (elapsed_q + 20'h1 >= cur_set_w) begin
          flick_q <= ~flick_q;
          elapsed_q <= 20'h0;
        end else if (elapsed_q == `TWF_VALUE_MAX) begin
          elapsed_q <= 20'h0;
        end else begin
          elapsed_q <= elapsed_q + 20'h1;
        end
      end else begin
        unit_q <= unit_q + 22'h1;
      end
    end
  end

  // Outputs and indicators
  wire out_one_w = flick_q ^ ctrl_q[`TWF_CTRL_INV_ONE];
  wire inst_w = ctrl_q[`TWF_CTRL_TWIN_LIMIT] ? flick_q : timing_q;
  wire out_two_w = inst_w ^ ctrl_q[`TWF_CTRL_INV_TWO];
  reg [5:0] ind_d;
  always @* begin
    case (ind_mode_w)
      `TWF_IND_DARK: ind_d = 6'h00;
      `TWF_IND_LIT: ind_d = 6'h3F;
      default: ind_d = ratio_pattern(pv_w, cur_set_w);
    endcase
  end

  // ON-count monitors: 0 overall, 1 and 2 per output
  reg [9:0] sub_q [0:2];
  reg [15:0] kilo_q [0:2];
  reg prev_one_q;
  reg prev_two_q;
  integer j;
  wire ev_one_w = control_output_one_out && !prev_one_q;
  wire ev_two_w = control_output_two_out && !prev_two_q;
  wire [2:0] ev_w = {ev_two_w, ev_one_w, ev_one_w | ev_two_w};
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      prev_one_q <= 1'b0;
      prev_two_q <= 1'b0;
    end else begin
      prev_one_q <= control_output_one_out;
      prev_two_q <= control_output_two_out;
    end
    for (j = 0; j < 3; j = j + 1) begin
      if (srst_in) begin
        sub_q[j] <= 10'h0;
        kilo_q[j] <= 16'h0;
      end else if (ev_w[j] && !(kilo_q[j] == 16'hFFFF && sub_q[j] == `TWF_KILO - 10'h1)) begin
        if (sub_q[j] == `TWF_KILO - 10'h1) begin
          sub_q[j] <= 10'h0;
          kilo_q[j] <= kilo_q[j] + 16'h1;
        end else begin
          sub_q[j] <= sub_q[j] + 10'h1;
        end
      end
    end
  end

  // Run time in tenths of a year
  reg [31:0] sec_ms_q;
  reg [31:0] tenth_s_q;
  reg [9:0] runtime_q;
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      sec_ms_q <= 32'h0;
      tenth_s_q <= 32'h0;
      runtime_q <= 10'h0;
    end else if (ms_tick_w) begin
      if (sec_ms_q == SEC_MS - 1) begin
        sec_ms_q <= 32'h0;
        if (tenth_s_q == TENTH_YEAR_S - 1) begin
          tenth_s_q <= 32'h0;
          if (runtime_q != 10'h3FF) begin
            runtime_q <= runtime_q + 10'h1;
          end
        end else begin
          tenth_s_q <= tenth_s_q + 32'h1;
        end
      end else begin
        sec_ms_q <= sec_ms_q + 32'h1;
      end
    end
  end

  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      control_output_one_out <= 1'b0;
      control_output_two_out <= 1'b0;
      indicators_out <= 6'h00;
      replacement_due_error_out <= 1'b0;
    end else begin
      control_output_one_out <= out_one_w;
      control_output_two_out <= out_two_w;
      indicators_out <= ind_d;
      replacement_due_error_out <= (alarm_q != 14'h0) &&
                                   (kilo_q[0] >= {2'h0, alarm_q});
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  reg aw_held_q;
  reg w_held_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  assign s_axi_awready_out = !aw_held_q && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_held_q && !s_axi_bvalid_out;
  wire do_wr_w = aw_held_q && w_held_q && !s_axi_bvalid_out;
  reg [31:0] wval_d;
  reg [19:0] wv20_d;
  always @* begin
    wval_d = 32'h0;
    case (aw_addr_q)
      `TWF_REG_CTRL: wval_d = ctrl_q;
      `TWF_REG_ON_SET: wval_d = {12'h0, on_set_q};
      `TWF_REG_OFF_SET: wval_d = {12'h0, off_set_q};
      `TWF_REG_ON_LIMIT: wval_d = {12'h0, on_limit_q};
      `TWF_REG_OFF_LIMIT: wval_d = {12'h0, off_limit_q};
      `TWF_REG_ALARM: wval_d = {18'h0, alarm_q};
      default: wval_d = 32'h0;
    endcase
    wval_d = merge(wval_d, w_data_q, w_strb_q);
    wv20_d = wval_d[19:0];
  end
  wire wv_big_w = (wval_d[31:20] != 12'h0);

  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= 2'h0;
      ctrl_q <= `TWF_CTRL_RESET;
      on_set_q <= 20'h0;
      off_set_q <= 20'h0;
      on_limit_q <= `TWF_VALUE_MAX;
      off_limit_q <= `TWF_VALUE_MAX;
      alarm_q <= `TWF_ALARM_RESET;
      power_evt_q <= 1'b0;
    end else begin
      power_evt_q <= 1'b0;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
      if (do_wr_w) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= 2'h2;
        case (aw_addr_q)
          `TWF_REG_CTRL: begin
            ctrl_q <= wval_d & `TWF_CTRL_MASK;
            s_axi_bresp_out <= 2'h0;
          end
          `TWF_REG_ON_SET: begin
            if (!wv_big_w && wv20_d <= on_limit_q) begin
              on_set_q <= wv20_d;
              s_axi_bresp_out <= 2'h0;
            end
          end
          `TWF_REG_OFF_SET: begin
            if (!wv_big_w && wv20_d <= off_limit_q) begin
              off_set_q <= wv20_d;
              s_axi_bresp_out <= 2'h0;
            end
          end
          `TWF_REG_ON_LIMIT: begin
            if (!wv_big_w && wv20_d >= `TWF_LIMIT_MIN && wv20_d <= `TWF_VALUE_MAX) begin
              on_limit_q <= wv20_d;
              s_axi_bresp_out <= 2'h0;
            end
          end
          `TWF_REG_OFF_LIMIT: begin
            if (!wv_big_w && wv20_d >= `TWF_LIMIT_MIN && wv20_d <= `TWF_VALUE_MAX) begin
              off_limit_q <= wv20_d;
              s_axi_bresp_out <= 2'h0;
            end
          end
          `TWF_REG_ALARM: begin
            if (wval_d <= {18'h0, `TWF_ALARM_MAX}) begin
              alarm_q <= wval_d[13:0];
              s_axi_bresp_out <= 2'h0;
            end
          end
          `TWF_REG_POWER: begin
            power_evt_q <= wval_d[0];
            s_axi_bresp_out <= 2'h0;
          end
          default: s_axi_bresp_out <= 2'h2;
        endcase
      end
    end
  end

  // AXI4-Lite read path; monitors have no write decode
  assign s_axi_arready_out = !s_axi_rvalid_out;
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= 2'h0;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= 2'h0;
      case (s_axi_araddr_in)
        `TWF_REG_CTRL: s_axi_rdata_out <= ctrl_q;
        `TWF_REG_ON_SET: s_axi_rdata_out <= {12'h0, on_set_q};
        `TWF_REG_OFF_SET: s_axi_rdata_out <= {12'h0, off_set_q};
        `TWF_REG_ON_LIMIT: s_axi_rdata_out <= {12'h0, on_limit_q};
        `TWF_REG_OFF_LIMIT: s_axi_rdata_out <= {12'h0, off_limit_q};
        `TWF_REG_ALARM: s_axi_rdata_out <= {18'h0, alarm_q};
        `TWF_REG_STATUS: s_axi_rdata_out <= {23'h0, indicators_out, replacement_due_error_out,
                                             flick_q, timing_q};
        `TWF_REG_PV: s_axi_rdata_out <= {12'h0, pv_w};
        `TWF_REG_CNT_ALL: s_axi_rdata_out <= {16'h0, kilo_q[0]};
        `TWF_REG_CNT_ONE: s_axi_rdata_out <= {16'h0, kilo_q[1]};
        `TWF_REG_CNT_TWO: s_axi_rdata_out <= {16'h0, kilo_q[2]};
        `TWF_REG_RUNTIME: s_axi_rdata_out <= {22'h0, runtime_q};
        `TWF_REG_POWER: s_axi_rdata_out <= 32'h0;
        default: begin
          s_axi_rdata_out <= 32'h0;
          s_axi_rresp_out <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

endmodule // twf_timer
`default_nettype wire

// ===== dv/twf_field.sv
// Field switch and sensor model: start, reset and gate contacts that bounce on every change
`timescale 1ns/100ps
`default_nettype none
module twf_field (
  input wire logic ref_clk_in,
  input wire logic [2:0] want_in,
  output logic [2:0] pins_out
);
  logic [2:0] last_q = 3'h0;
  logic [2:0] chg_q = 3'h0;
  logic [3:0] bnc_q = 4'h0;
  initial pins_out = 3'h0;
  // Changed contacts chatter for six cycles before they settle
  always @(posedge ref_clk_in) begin
    if (want_in != last_q) begin
      chg_q <= want_in ^ last_q;
      last_q <= want_in;
      bnc_q <= 4'h6;
    end else if (bnc_q != 4'h0) begin
      bnc_q <= bnc_q - 4'h1;
    end
    pins_out <= want_in ^ (chg_q & {3{bnc_q[0]}});
  end
endmodule // twf_field
`default_nettype wire

// ===== dv/twf_timer_sva.sv
// Port checker of the twin flicker timer
`timescale 1ns/100ps
`default_nettype none
module twf_timer_sva (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic control_output_one_out,
  input wire logic [5:0] indicators_out,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  a_reset_quiet: assert property (
    disable iff (1'b0) srst_in |=> !s_axi_bvalid_out && !s_axi_rvalid_out
      && !control_output_one_out && indicators_out == 6'h00)
    else $error("outputs not cleared by reset");
  a_bresp_taken: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
    else $error("write response not released");
  a_rresp_taken: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
    else $error("read response not released");
  a_ar_blocked: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read address taken while answer pending");
  a_aw_blocked: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken while answer pending");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out)
    else $error("write answer late");
  a_ind_fill: assert property (
    ((~indicators_out) & ((~indicators_out) + 6'h01)) == 6'h00)
    else $error("indicators not filled from the left");
endmodule // twf_timer_sva
bind twf_timer twf_timer_sva twf_timer_sva_inst (
  .ref_clk_in(ref_clk_in), .srst_in(srst_in),
  .control_output_one_out(control_output_one_out), .indicators_out(indicators_out),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in));
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking testbench of the twin flicker timer
`timescale 1ns/100ps
`default_nettype none
`include "twf_defines.vh"
module testbench;
  logic ref_clk_in, srst_in, awv, wv, arv, brd, rrd;
  logic [3:0] ws;
  logic [2:0] want;
  logic [7:0] awa, ara;
  logic [31:0] wd, d;
  logic [1:0] r;
  logic [19:0] lim, v;
  logic [19:0] setv [2];
  wire [2:0] pins;
  wire awr, wr_rdy, bv, arr, rv, control_output_one, control_output_two, err;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [5:0] ind;
  integer miscompares, checks, cyc, i, n, hi, lo;
  twf_timer #(.MS_CYCLES(20), .TENTH_YEAR_S(3), .SEC_MS(4)) twf_timer_inst (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .start_in(pins[0]), .reset_in(pins[1]),
    .gate_in(pins[2]), .control_output_one_out(control_output_one), .control_output_two_out(control_output_two),
    .indicators_out(ind), .replacement_due_error_out(err),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr_rdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(brd), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rrd));
  twf_field twf_field_inst (.ref_clk_in(ref_clk_in), .want_in(want), .pins_out(pins));
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  task print_verdict;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Both halves offered together, each dropped at the edge that takes it
  task wr(input [7:0] a, input [31:0] dd, input [1:0] er);
    logic hb;
    begin
      awa <= a;
      wd <= dd;
      awv <= 1'b1;
      wv <= 1'b1;
      hb = 1'b0;
      while (!hb) begin
        @(posedge ref_clk_in);
        if (awv && awr) awv <= 1'b0;
        if (wv && wr_rdy) wv <= 1'b0;
        if (bv && brd) begin
          r = bresp;
          brd <= 1'b0;
          hb = 1'b1;
        end else begin
          brd <= 1'b1;
        end
      end
      chk({30'h0, r}, {30'h0, er});
    end
  endtask
  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    logic hv;
    begin
      ara <= a;
      arv <= 1'b1;
      hv = 1'b0;
      while (!hv) begin
        @(posedge ref_clk_in);
        if (arv && arr) arv <= 1'b0;
        if (rv && rrd) begin
          d = rdata;
          r = rresp;
          rrd <= 1'b0;
          hv = 1'b1;
        end else begin
          rrd <= 1'b1;
        end
      end
      chk(d, ed);
      chk({30'h0, r}, {30'h0, er});
    end
  endtask
  function [1:0] set_resp(input [19:0] val, input [19:0] top);
    set_resp = (val > top) ? 2'h2 : 2'h0;
  endfunction
  initial begin
    srst_in = 1'b1;
    want = 3'h0;
    {awv, wv, arv, brd, rrd, awa, ara, wd} = '0;
    ws = 4'hF;
    {miscompares, checks, cyc} = '0;
    setv[0] = 20'h0;
    setv[1] = 20'h0;
    void'($urandom(64595));
    repeat (4) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    rd(`TWF_REG_CTRL, 32'h1, 2'h0);
    rd(`TWF_REG_ALARM, 32'h64, 2'h0);
    rd(`TWF_REG_ON_LIMIT, 32'hF423F, 2'h0);
    rd(`TWF_REG_CNT_ALL, 32'h0, 2'h0);
    rd(8'h3C, 32'h0, 2'h2);
    wr(`TWF_REG_CNT_ALL, 32'h5, 2'h2);
    wr(`TWF_REG_CNT_TWO, 32'h5, 2'h2);
    wr(`TWF_REG_RUNTIME, 32'h5, 2'h2);
    wr(`TWF_REG_ALARM, 32'h2710, 2'h2);
    wr(`TWF_REG_ALARM, 32'h270F, 2'h0);
    rd(`TWF_REG_ALARM, 32'h270F, 2'h0);
    wr(`TWF_REG_ON_LIMIT, 32'h0, 2'h2);
    wr(`TWF_REG_OFF_LIMIT, 32'hF4240, 2'h2);
    $display("register access test done");
    for (i = 0; i < 10; i = i + 1) begin
      lim = $urandom_range(999998, 1);
      v = (i < 2) ? lim + i[19:0] : $urandom_range(999999, 0);
      wr(i[0] ? `TWF_REG_OFF_LIMIT : `TWF_REG_ON_LIMIT, {12'h0, lim}, 2'h0);
      wr(i[0] ? `TWF_REG_OFF_SET : `TWF_REG_ON_SET, {12'h0, v}, set_resp(v, lim));
      if (v <= lim) setv[i[0]] = v;
      rd(i[0] ? `TWF_REG_OFF_SET : `TWF_REG_ON_SET, {12'h0, setv[i[0]]}, 2'h0);
    end
    wr(`TWF_REG_ON_LIMIT, 32'hF423F, 2'h0);
    wr(`TWF_REG_OFF_LIMIT, 32'hF423F, 2'h0);
    $display("set limit test done");
    // ON 2 x 100 ms and OFF 150 x 1 ms keep relay-safe interval lengths
    wr(`TWF_REG_ON_SET, 32'h2, 2'h0);
    wr(`TWF_REG_OFF_SET, 32'h96, 2'h0);
    wr(`TWF_REG_CTRL, 32'h2009, 2'h0);
    want <= 3'h1;
    repeat (8) @(posedge ref_clk_in);
    want <= 3'h0;
    repeat (60) @(posedge ref_clk_in);
    rd(`TWF_REG_STATUS, 32'h0, 2'h0);
    want <= 3'h1;
    repeat (70) @(posedge ref_clk_in);
    chk({31'h0, control_output_one}, 32'h0);
    rd(`TWF_REG_STATUS, 32'h1, 2'h0);
    want <= 3'h0;
    for (n = 0; !control_output_one && n < 5000; n = n + 1) @(posedge ref_clk_in);
    for (hi = 0; control_output_one && hi < 5000; hi = hi + 1) @(posedge ref_clk_in);
    for (lo = 0; !control_output_one && lo < 5000; lo = lo + 1) @(posedge ref_clk_in);
    chk(hi - lo, 32'd1000);
    want <= 3'h1;
    repeat (60) @(posedge ref_clk_in);
    wr(`TWF_REG_CTRL, 32'h8, 2'h0);
    repeat (3) @(posedge ref_clk_in);
    chk({31'h0, control_output_one}, 32'h0);
    rd(`TWF_REG_PV, 32'h0, 2'h0);
    wr(`TWF_REG_CTRL, 32'hD, 2'h0);
    repeat (3) @(posedge ref_clk_in);
    chk({31'h0, control_output_one}, 32'h1);
    chk({31'h0, control_output_two}, 32'h1);
    wr(`TWF_REG_CTRL, 32'h27D, 2'h0);
    repeat (3) @(posedge ref_clk_in);
    chk({26'h0, ind}, 32'h3F);
    chk({31'h0, control_output_one}, 32'h0);
    chk({31'h0, control_output_two}, 32'h0);
    wr(`TWF_REG_CTRL, 32'h10D, 2'h0);
    repeat (3) @(posedge ref_clk_in);
    chk({26'h0, ind}, 32'h0);
    $display("flicker test done");
    wr(`TWF_REG_ON_SET, 32'h0, 2'h0);
    wr(`TWF_REG_OFF_SET, 32'h0, 2'h0);
    wr(`TWF_REG_ALARM, 32'h1, 2'h0);
    wr(`TWF_REG_CTRL, 32'hD, 2'h0);
    for (n = 0; err !== 1'b1 && n < 60000; n = n + 1) @(posedge ref_clk_in);
    chk({31'h0, err}, 32'h1);
    rd(`TWF_REG_CNT_ALL, 32'h1, 2'h0);
    wr(`TWF_REG_ALARM, 32'h0, 2'h0);
    repeat (3) @(posedge ref_clk_in);
    chk({31'h0, err}, 32'h0);
    $display("alarm test done");
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
